// >>> inc/ppi_cfg.svh
`ifndef PPI_CFG_SVH
`define PPI_CFG_SVH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define PPI_A_CTRL 8'h00
`define PPI_A_HSTART 8'h04
`define PPI_A_HACT 8'h08
`define PPI_A_VSTART 8'h0c
`define PPI_A_VACT 8'h10
`define PPI_A_STATUS 8'h14
`define PPI_A_POS 8'h18

// ---------------------------------------------------------------
// control field positions
// ---------------------------------------------------------------
`define PPI_C_CAPFALL 0
`define PPI_C_HSLOW 1
`define PPI_C_VSLOW 2
`define PPI_C_MKLOW 3
`define PPI_C_FMT16 4
`define PPI_C_PATTERN 5
`define PPI_C_AUTO 6
`define PPI_C_NARROW 7

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PPI_CTRL_RST 8'h00
`define PPI_HSTART_RST 12'h000
`define PPI_HACT_RST 12'h356
`define PPI_VSTART_RST 11'h000
`define PPI_VACT_RST 11'h1e0

// ---------------------------------------------------------------
// mirror array limits and format constants
// ---------------------------------------------------------------
`define PPI_MAX_COLS 10'h356
`define PPI_MAX_ROWS 9'h1e0
`define PPI_LAST_BEAT24 2'h2
`define PPI_LAST_BEAT16 2'h1
`define PPI_LAST_PLANE24 5'h17
`define PPI_LAST_PLANE16 5'h0f

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PPI_CLK_HZ 250000000
`define PPI_PAT24_HZ 2880
`define PPI_PAT16_HZ 1008
`define PPI_PWM_UNIT 64

`endif

// >>> inc/ppi_pkg.sv
package ppi_pkg;

	// ---------------------------------------------------------------
	// shared types
	// ---------------------------------------------------------------
	typedef logic [4:0] ppi_plane_t; // bit-plane index 0..23
	typedef logic [19:0] ppi_dur_t; // plane hold time in clocks

	// frame tracking, one-hot
	typedef enum logic [1:0] {
		PPI_FS_WAIT = 2'b01,
		PPI_FS_FRAME = 2'b10
	} ppi_fs_t;

	// plane sequencer, one-hot
	typedef enum logic [1:0] {
		PPI_SQ_IDLE = 2'b01,
		PPI_SQ_SHOW = 2'b10
	} ppi_sq_t;

	// whole state of the capture module
	typedef struct packed {
		logic [2:0] pclk_s;
		logic [1:0] hs_s;
		logic [1:0] vs_s;
		logic [1:0] dv_s;
		logic [1:0] mk_s;
		logic [1:0][23:0] pd_s;
		logic [7:0] ctrl;
		logic [11:0] hstart;
		logic [11:0] hact;
		logic [10:0] vstart;
		logic [10:0] vact;
		logic [31:0] rdata;
		logic hs_q;
		logic vs_q;
		logic [11:0] hcnt;
		logic [10:0] vcnt;
		logic [1:0] beat;
		logic [15:0] acc;
		logic [9:0] col;
		logic [8:0] row;
		logic line_had;
		logic blocked;
		logic [15:0] frames;
		logic go;
		logic out_wr;
		logic [9:0] out_col;
		logic [8:0] out_row;
		logic [23:0] out_planes;
		ppi_fs_t fs;
	} ppi_cap_st_t;

	// whole state of the plane sequencer
	typedef struct packed {
		ppi_sq_t sq;
		ppi_plane_t plane;
		ppi_dur_t cnt;
		logic fmt16;
		logic pattern;
		logic stb;
	} ppi_seq_st_t;

endpackage

// >>> inc/ppi_seq_if.sv
`timescale 1ns/10ps
// carries a finished frame to the plane sequencer and the plane back
interface ppi_seq_if;
	logic frame_go; // one-cycle pulse: new image is complete
	logic fmt16; // image uses 16-bit packing
	logic pattern; // image is a binary pattern
	ppi_pkg::ppi_plane_t plane; // plane on the mirrors now
	logic plane_stb; // pulse when a plane starts

	modport src (output frame_go, fmt16, pattern, input plane, plane_stb);
	modport seq (input frame_go, fmt16, pattern, output plane, plane_stb);
endinterface

// >>> logic/ppi_seq.sv
`timescale 1ns/10ps
`include "ppi_cfg.svh"
// binary pulse-duration sequencer: walks the bit planes of the last
// complete image, holding each for its weighted time, or an equal slot for patterns
module ppi_seq #(
	parameter int UNIT_CYC = `PPI_PWM_UNIT,
	parameter int PAT24_CYC = 1,
	parameter int PAT16_CYC = 1
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// link to the capture side
	ppi_seq_if.seq sif
);
	import ppi_pkg::*;

	ppi_seq_st_t s_reg; // registered state
	ppi_seq_st_t s_next; // next state
	ppi_plane_t last; // final plane index of the current image
	ppi_dur_t dur; // hold time of the plane being loaded
	ppi_plane_t nplane; // plane being loaded

	assign sif.plane = s_reg.plane;
	assign sif.plane_stb = s_reg.stb;

	// -----------------------------------------------------------
	// next state
	// -----------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.stb = 1'b0;
		last = (s_reg.pattern & s_reg.fmt16) ? `PPI_LAST_PLANE16 :
			`PPI_LAST_PLANE24;
		nplane = (s_reg.plane == last) ? 5'h00 : s_reg.plane + 5'h01;
		dur = '0;
		case (s_reg.sq)
			PPI_SQ_IDLE: begin
				// nothing shown until the first full image
			end
			PPI_SQ_SHOW: begin
				if (s_reg.cnt <= 20'h00001) begin
					// current image repeats until a new one arrives
					s_next.plane = nplane;
					s_next.stb = 1'b1;
				end else begin
					s_next.cnt = s_reg.cnt - 20'h00001;
				end
			end
			default: begin
				s_next.sq = PPI_SQ_IDLE;
			end
		endcase
		if (sif.frame_go) begin
			// new image restarts the sequence at plane zero
			s_next.sq = PPI_SQ_SHOW;
			s_next.plane = 5'h00;
			s_next.fmt16 = sif.fmt16;
			s_next.pattern = sif.pattern;
			s_next.stb = 1'b1;
		end
		// patterns get equal slots, video gets binary weights
		if (s_next.pattern) begin
			dur = s_next.fmt16 ? ppi_dur_t'(PAT16_CYC) :
				ppi_dur_t'(PAT24_CYC);
		end else begin
			dur = ppi_dur_t'(UNIT_CYC) << s_next.plane[2:0];
		end
		if (s_next.stb) begin
			s_next.cnt = dur;
		end
	end

	// -----------------------------------------------------------
	// state register
	// -----------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '{sq: PPI_SQ_IDLE, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end
endmodule

// >>> logic/ppi_top.sv
`timescale 1ns/10ps
`include "ppi_cfg.svh"
module ppi_top #(
	parameter int PAT24_CYC = (`PPI_CLK_HZ + `PPI_PAT24_HZ - 1) /
		`PPI_PAT24_HZ,
	parameter int PAT16_CYC = (`PPI_CLK_HZ + `PPI_PAT16_HZ - 1) /
		`PPI_PAT16_HZ,
	parameter int UNIT_CYC = `PPI_PWM_UNIT
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// pixel bus pins
	input wire logic pclk,
	input wire logic hsync,
	input wire logic vsync,
	input wire logic data_valid_input,
	input wire logic [23:0] pdata,
	input wire logic frame_update_mask,
	// mirror array side
	output logic mirror_wr,
	output logic [9:0] mirror_col,
	output logic [8:0] mirror_row,
	output logic [23:0] mirror_planes,
	output ppi_pkg::ppi_plane_t mirror_plane,
	output logic mirror_plane_stb
);
	import ppi_pkg::*;

	ppi_cap_st_t s_reg; // registered state
	ppi_cap_st_t s_next; // next state
	ppi_seq_if sif (); // link to the plane sequencer

	logic cap; // capture edge seen this cycle
	logic hs_a; // line sync, active high
	logic vs_a; // frame sync, active high
	logic mk_a; // frame mask, active high
	logic hs_edge; // leading edge of line sync
	logic vs_edge; // leading edge of frame sync
	logic win; // inside active pixel window
	logic done; // a whole pixel has been assembled
	logic [23:0] pd; // synchronised data bus
	logic [23:0] pix; // assembled pixel
	logic [1:0] last_beat; // final beat index of a narrow pixel
	logic [12:0] hend; // first column past the window
	logic [11:0] vend; // first line past the window

	// -----------------------------------------------------------
	// pixel formatting
	// -----------------------------------------------------------
	// expands 565 to 888 by repeating high bits; pattern data
	// keeps its low 16 bits (upper byte cleared) or all 24 bits, so every bit lands on its own plane
	function automatic logic [23:0] fmt_pix(input logic [23:0] p,
		input logic f16, input logic pat);
		logic [23:0] r;
		r = p;
		if (pat) begin
			r = f16 ? {8'h00, p[15:0]} : p;
		end else if (f16) begin
			r = {p[15:11], p[15:13], p[10:5], p[10:9],
				p[4:0], p[4:2]};
		end
		return r; // 888 passes as is
	endfunction

	// -----------------------------------------------------------
	// next state
	// -----------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.go = 1'b0;
		s_next.out_wr = 1'b0;
		s_next.rdata = 32'h0000_0000;
		done = 1'b0;
		pix = 24'h00_0000;
		// every pin passes two flops before use
		s_next.pclk_s = {s_reg.pclk_s[1:0], pclk};
		s_next.hs_s = {s_reg.hs_s[0], hsync};
		s_next.vs_s = {s_reg.vs_s[0], vsync};
		s_next.dv_s = {s_reg.dv_s[0], data_valid_input};
		s_next.mk_s = {s_reg.mk_s[0], frame_update_mask};
		s_next.pd_s = {s_reg.pd_s[0], pdata};
		pd = s_reg.pd_s[1];
		// capture edge chosen by software
		if (s_reg.ctrl[`PPI_C_CAPFALL]) begin
			cap = s_reg.pclk_s[2] & ~s_reg.pclk_s[1];
		end else begin
			cap = ~s_reg.pclk_s[2] & s_reg.pclk_s[1];
		end
		// polarity correction of both syncs and the mask
		hs_a = s_reg.hs_s[1] ^ s_reg.ctrl[`PPI_C_HSLOW];
		vs_a = s_reg.vs_s[1] ^ s_reg.ctrl[`PPI_C_VSLOW];
		mk_a = s_reg.mk_s[1] ^ s_reg.ctrl[`PPI_C_MKLOW];
		hs_edge = hs_a & ~s_reg.hs_q;
		vs_edge = vs_a & ~s_reg.vs_q;
		hend = {1'b0, s_reg.hstart} + {1'b0, s_reg.hact};
		vend = {1'b0, s_reg.vstart} + {1'b0, s_reg.vact};
		last_beat = s_reg.ctrl[`PPI_C_FMT16] ? `PPI_LAST_BEAT16 :
			`PPI_LAST_BEAT24;
		// window from counters or from the valid pin
		if (s_reg.ctrl[`PPI_C_AUTO]) begin
			win = (s_reg.hcnt >= s_reg.hstart) &&
				({1'b0, s_reg.hcnt} < hend) &&
				(s_reg.vcnt >= s_reg.vstart) &&
				({1'b0, s_reg.vcnt} < vend);
		end else begin
			win = s_reg.dv_s[1];
		end

		if (cap) begin
			s_next.hs_q = hs_a;
			s_next.vs_q = vs_a;
			// column counter restarts at each line sync
			if (hs_edge) begin
				s_next.hcnt = 12'h000;
				s_next.col = 10'h000;
				s_next.beat = 2'h0;
			end else if (s_reg.hcnt != 12'hfff) begin
				s_next.hcnt = s_reg.hcnt + 12'h001;
			end
			if (vs_edge) begin
				// frame boundary: hand a finished image to the planes
				if (s_reg.fs == PPI_FS_FRAME) begin
					s_next.frames = s_reg.frames + 16'h0001;
					s_next.go = ~s_reg.blocked;
				end
				// mask is only legal to move in blanking, so the
				// level here holds for the whole frame
				s_next.blocked = mk_a;
				s_next.fs = PPI_FS_FRAME;
				s_next.vcnt = 11'h000;
				s_next.row = 9'h000;
				s_next.line_had = 1'b0;
			end else if (hs_edge) begin
				if (s_reg.vcnt != 11'h7ff) begin
					s_next.vcnt = s_reg.vcnt + 11'h001;
				end
				if (s_reg.line_had && s_reg.row != 9'h1ff) begin
					s_next.row = s_reg.row + 9'h001;
				end
				s_next.line_had = 1'b0;
			end
			// data taken only inside the window
			if (win && !hs_edge && !vs_edge &&
				s_reg.fs == PPI_FS_FRAME) begin
				if (!s_reg.ctrl[`PPI_C_NARROW]) begin
					done = 1'b1;
					pix = pd;
				end else if (s_reg.beat == last_beat) begin
					// several pixel clocks per pixel, first beat
					// most significant
					done = 1'b1;
					pix = s_reg.ctrl[`PPI_C_FMT16] ?
						{8'h00, s_reg.acc[7:0], pd[7:0]} :
						{s_reg.acc, pd[7:0]};
					s_next.beat = 2'h0;
				end else begin
					s_next.acc = {s_reg.acc[7:0], pd[7:0]};
					s_next.beat = s_reg.beat + 2'h1;
				end
			end
			if (done) begin
				s_next.line_had = 1'b1;
				if (s_reg.col != 10'h3ff) begin
					s_next.col = s_reg.col + 10'h001;
				end
				// columns and rows past the array are dropped
				if (s_reg.col < `PPI_MAX_COLS &&
					s_reg.row < `PPI_MAX_ROWS && !s_reg.blocked) begin
					s_next.out_wr = 1'b1;
					s_next.out_col = s_reg.col;
					s_next.out_row = s_reg.row;
					s_next.out_planes = fmt_pix(pix,
						s_reg.ctrl[`PPI_C_FMT16],
						s_reg.ctrl[`PPI_C_PATTERN]);
				end
			end
		end

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				`PPI_A_CTRL: s_next.ctrl = reg_wdata[7:0];
				`PPI_A_HSTART: s_next.hstart = reg_wdata[11:0];
				`PPI_A_HACT: s_next.hact = reg_wdata[11:0];
				`PPI_A_VSTART: s_next.vstart = reg_wdata[10:0];
				`PPI_A_VACT: s_next.vact = reg_wdata[10:0];
				default: begin
					// read-only or unmapped: ignored
				end
			endcase
		end
		// register reads, data valid only in the following cycle
		if (reg_rd) begin
			case (reg_addr)
				`PPI_A_CTRL: s_next.rdata = {24'h00_0000, s_reg.ctrl};
				`PPI_A_HSTART: s_next.rdata = {20'h0_0000, s_reg.hstart};
				`PPI_A_HACT: s_next.rdata = {20'h0_0000, s_reg.hact};
				`PPI_A_VSTART: s_next.rdata = {21'h00_0000, s_reg.vstart};
				`PPI_A_VACT: s_next.rdata = {21'h00_0000, s_reg.vact};
				`PPI_A_STATUS: s_next.rdata = {s_reg.frames, 13'h0000,
					mk_a, s_reg.blocked, s_reg.fs == PPI_FS_FRAME};
				`PPI_A_POS: s_next.rdata = {7'h00, s_reg.row, 6'h00,
					s_reg.col};
				default: s_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	// -----------------------------------------------------------
	// state register
	// -----------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '{ctrl: `PPI_CTRL_RST, hstart: `PPI_HSTART_RST,
				hact: `PPI_HACT_RST, vstart: `PPI_VSTART_RST,
				vact: `PPI_VACT_RST, fs: PPI_FS_WAIT, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// -----------------------------------------------------------
	// plane sequencer
	// -----------------------------------------------------------
	// the sequencer reads the format from the control register at the hand-over,
	// so a control change mid-frame applies to the image then handed over
	assign sif.frame_go = s_reg.go;
	assign sif.fmt16 = s_reg.ctrl[`PPI_C_FMT16];
	assign sif.pattern = s_reg.ctrl[`PPI_C_PATTERN];

	ppi_seq #(
		.UNIT_CYC(UNIT_CYC),
		.PAT24_CYC(PAT24_CYC),
		.PAT16_CYC(PAT16_CYC)
	) u_seq (
		.clock(clock),
		.rst_n(rst_n),
		.sif(sif)
	);

	// -----------------------------------------------------------
	// outputs
	// -----------------------------------------------------------
	assign reg_rdata = s_reg.rdata;
	assign mirror_wr = s_reg.out_wr;
	assign mirror_col = s_reg.out_col;
	assign mirror_row = s_reg.out_row;
	assign mirror_planes = s_reg.out_planes;
	assign mirror_plane = sif.plane;
	assign mirror_plane_stb = sif.plane_stb;
endmodule

// >>> verification/ppi_assertions.sv
`timescale 1ns/10ps
// watches the register port and the mirror side of the pixel port
module ppi_assertions (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// mirror array side
	input wire logic mirror_wr,
	input wire logic [9:0] mirror_col,
	input wire logic [8:0] mirror_row,
	input wire logic [23:0] mirror_planes,
	input wire ppi_pkg::ppi_plane_t mirror_plane,
	input wire logic mirror_plane_stb
);
	import ppi_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	rdata_idle_a:
		assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
		else $error("read data outside its slot");
	ctrl_back_a:
		assert property (reg_wr && reg_addr == 8'h00 ##1 reg_rd &&
			reg_addr == 8'h00 |=> reg_rdata == ($past(reg_wdata, 2) & 32'hff))
		else $error("control readback wrong");
	wr_pulse_a:
		assert property (mirror_wr |=> !mirror_wr)
		else $error("pixel write longer than one cycle");
	wr_hold_a:
		assert property (!mirror_wr |->
			$stable({mirror_col, mirror_row, mirror_planes}))
		else $error("pixel data moved without a write");
	col_max_a:
		assert property (mirror_wr |-> mirror_col < 10'h356)
		else $error("column beyond array");
	row_max_a:
		assert property (mirror_wr |-> mirror_row < 9'h1e0)
		else $error("row beyond array");
	stb_pulse_a:
		assert property (mirror_plane_stb |=> !mirror_plane_stb)
		else $error("plane strobe longer than one cycle");
	plane_move_a:
		assert property (!$stable(mirror_plane) |-> mirror_plane_stb)
		else $error("plane changed without strobe");
	plane_step_a:
		assert property (mirror_plane_stb && mirror_plane != 5'h0 |->
			mirror_plane == $past(mirror_plane) + 5'h1)
		else $error("plane skipped");
	plane_max_a:
		assert property (mirror_plane <= 5'h17)
		else $error("plane index too high");
	// main scenarios seen
	cover property (mirror_wr);
	cover property (mirror_plane_stb && mirror_plane == 5'h17);
	cover property (mirror_plane == 5'hf ##1 mirror_plane == 5'h0);
endmodule

bind ppi_top ppi_assertions chk (
	.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .mirror_wr(mirror_wr), .mirror_col(mirror_col),
	.mirror_row(mirror_row), .mirror_planes(mirror_planes),
	.mirror_plane(mirror_plane), .mirror_plane_stb(mirror_plane_stb)
);

// >>> verification/ppi_host_model.sv
`timescale 1ns/10ps
// host video source: free running pixel clock, syncs and pixel data
module ppi_host_model (
	// pixel bus pins
	output logic pclk,
	output logic hsync,
	output logic vsync,
	output logic data_valid_input,
	output logic [23:0] pdata,
	// bus options from the bench
	input wire logic fall_cap,
	input wire logic hs_low,
	input wire logic vs_low,
	input wire logic dv_off
);
	logic hs = 1'b0;
	logic vs = 1'b0;
	// about 42 MHz, well inside what the oversampler can follow
	initial begin
		pclk = 1'b0;
		data_valid_input = 1'b0;
		pdata = 24'h0;
		forever #12 pclk = ~pclk;
	end
	assign hsync = hs ^ hs_low;
	assign vsync = vs ^ vs_low;
	// pixel value of row r, column c
	function automatic logic [23:0] pix(input logic [23:0] s, input int r,
		input int c);
		return s ^ {r[7:0], c[15:0]};
	endfunction
	// sequencer sync mode is taken as automatic
	// frame: vsync line, two porch lines, r rows, one front porch line
	task automatic send_frame(input int r, input int n, input int bt,
		input logic [23:0] s);
		int act;
		int sh;
		logic [23:0] p;
		for (int l = 0; l < r + 4; l++) begin
			for (int t = 0; t < n * bt + 16; t++) begin
				// launch away from the capture edge
				if (fall_cap) @(posedge pclk);
				else @(negedge pclk);
				hs = t < 4;
				if (t == 2) vs = l == 0;
				act = l > 2 && l < r + 3 && t > 7 && t < n * bt + 8;
				p = pix(s, l - 3, (t - 8) / bt);
				sh = (bt - 1 - (t - 8) % bt) * 8;
				data_valid_input = act && !dv_off;
				// a released bus does not keep its last value
				if (!act) pdata = ~pdata;
				else if (bt == 1) pdata = p;
				else pdata = {~pdata[23:8], p[sh +: 8]};
			end
		end
	endtask
endmodule

// >>> verification/ppi_top_tb_top.sv
`timescale 1ns/10ps
`include "ppi_cfg.svh"
module ppi_top_tb_top;
	import ppi_pkg::*;
	// shortened plane times so the run stays short
	localparam int P24 = 20;
	localparam int P16 = 30;
	localparam int U = 2;
	localparam int LIMIT = 90000;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic pclk, hsync, vsync, dv, m_wr, m_stb;
	logic mk = 1'b0, fall_cap = 1'b0, hs_low = 1'b0, vs_low = 1'b0;
	logic dv_off = 1'b0;
	logic [23:0] pdata, m_pl;
	logic [9:0] m_col;
	logic [8:0] m_row;
	ppi_plane_t m_plane;
	int fail_count = 0, num_checks = 0, cyc = 0, wr_cnt = 0, last_t = 0;
	int e_cols = 1;
	logic e_f16 = 0, e_pat = 0, m_pat = 0, m_f16 = 0, chk_dur = 0;
	logic [31:0] seed = 32'h0;

	ppi_top #(.PAT24_CYC(P24), .PAT16_CYC(P16), .UNIT_CYC(U)) dut (
		.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pclk(pclk), .hsync(hsync), .vsync(vsync),
		.data_valid_input(dv), .pdata(pdata), .frame_update_mask(mk),
		.mirror_wr(m_wr), .mirror_col(m_col), .mirror_row(m_row),
		.mirror_planes(m_pl), .mirror_plane(m_plane),
		.mirror_plane_stb(m_stb));
	ppi_host_model host (.pclk(pclk), .hsync(hsync), .vsync(vsync),
		.data_valid_input(dv), .pdata(pdata), .fall_cap(fall_cap),
		.hs_low(hs_low), .vs_low(vs_low), .dv_off(dv_off));

	initial forever #2 clock = ~clock;

	task automatic check(input string w, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", w, e, g);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// planes the array should get for one received pixel
	function automatic logic [23:0] expp(input logic [23:0] p);
		if (!e_f16) return p;
		if (e_pat) return {8'h0, p[15:0]};
		return {p[15:11], p[15:13], p[10:5], p[10:9], p[4:0], p[4:2]};
	endfunction

	// hold time of plane k
	function automatic int dur(input logic [4:0] k);
		if (m_pat) return m_f16 ? P16 : P24;
		return U << (k % 8);
	endfunction

	// one register write (optional) then a read, back to back
	task automatic acc(input logic [7:0] a, input logic [31:0] d,
		input logic w, output logic [31:0] q);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		if (w) begin
			@(posedge clock);
			reg_wr <= 1'b0;
			reg_rd <= 1'b1;
		end
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask

	task automatic setw(input logic [7:0] a, input logic [11:0] v);
		logic [31:0] q;
		acc(a, ($urandom & 32'hfffff000) | v, 1'b1, q);
		check("window_reg", {20'h0, v}, q);
	endtask

	task automatic frame(input logic [7:0] c, input int r, input int n,
		input logic m, input int want);
		logic [31:0] q;
		acc(`PPI_A_CTRL, {24'h0, c}, 1'b1, q);
		check("ctrl", {24'h0, c}, q);
		@(posedge clock);
		mk <= m;
		fall_cap <= c[0];
		hs_low <= c[1];
		vs_low <= c[2];
		dv_off <= c[6];
		#1 e_f16 = c[4];
		e_pat = c[5];
		e_cols = n < 854 ? n : 854;
		wr_cnt = 0;
		seed = $urandom;
		host.send_frame(r, n, c[7] ? (c[4] ? 2 : 3) : 1, seed[23:0]);
		repeat (8) @(posedge clock);
		check("writes", want, wr_cnt);
	endtask

	// ------------------------------------------------------------
	// monitor of the mirror side and the run limit
	// ------------------------------------------------------------
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (m_wr === 1'b1) begin
			check("position", (wr_cnt / e_cols) * 1024 + wr_cnt % e_cols,
				{m_row, m_col});
			check("planes", expp(host.pix(seed[23:0], wr_cnt / e_cols,
				wr_cnt % e_cols)), m_pl);
			wr_cnt++;
		end
		if (m_stb === 1'b1) begin
			if (chk_dur && m_plane !== 5'h0)
				check("plane_time", dur(m_plane - 5'h1), cyc - last_t);
			if (chk_dur && m_pat && m_f16)
				check("plane16_top", 1, m_plane < 5'h10);
			last_t = cyc;
		end
		// limit checked last so nothing runs after the closing report
		if (cyc == LIMIT) begin
			fail_count++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] q;
		static logic [7:0] md [9] = '{8'h00, 8'h01, 8'h10, 8'h30, 8'h20,
			8'h80, 8'h90, 8'h06, 8'h40};
		static logic [7:0] dm [3] = '{8'h20, 8'h30, 8'h00};
		static logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
			8'h1c};
		static logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h356, 32'h0,
			32'h1e0, 32'h0};
		int r;
		int n;
		void'($urandom(32'h085e0855));
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		foreach (ra[i]) begin
			acc(ra[i], 32'h0, 1'b0, q);
			check("reset_value", rv[i], q);
		end
		// an unmapped write must leave nothing readable behind
		acc(8'h1c, $urandom, 1'b1, q);
		check("unmapped", 32'h0, q);
		foreach (md[i]) begin
			r = 2 + $urandom % 3;
			n = 4 + $urandom % 9;
			if (md[i][6]) begin
				// the column count seen at a capture is that of the one
				// before, so data from the eighth capture needs 7
				setw(`PPI_A_HSTART, 12'h7);
				setw(`PPI_A_HACT, n[11:0]);
				setw(`PPI_A_VSTART, 12'h3);
				setw(`PPI_A_VACT, r[11:0]);
			end
			frame(md[i], r, n, 1'b0, r * n);
		end
		frame(8'h00, 2, 4, 1'b1, 0);
		// mask still high: level, blocked and in-frame all set
		acc(`PPI_A_STATUS, 32'h0, 1'b0, q);
		check("status", 32'h7, q & 32'h7);
		// two received lines moved the row to 2, last sync cleared column
		acc(`PPI_A_POS, 32'h0, 1'b0, q);
		check("position_reg", 32'h0002_0000, q);
		frame(8'h08, 2, 4, 1'b0, 0);
		frame(8'h08, 2, 4, 1'b1, 8);
		frame(8'h00, 1, 856, 1'b0, 854);
		foreach (dm[i]) begin
			frame(dm[i], 2, 4, 1'b0, 8);
			frame(dm[i], 2, 4, 1'b0, 8);
			@(negedge clock);
			m_pat = dm[i][5];
			m_f16 = dm[i][4];
			chk_dur = 1'b1;
			repeat (1600) @(posedge clock);
			@(negedge clock);
			chk_dur = 1'b0;
		end
		stop_test();
	end
endmodule
